// ===== hw/abx_pkg.sv
// Package for the arithmetic, bit and branch execution block.
// Assumes one core clock, synchronous active-low reset, AXI4-Lite access.
//
// Contract
// - Add working register and addressed file register.
// - Destination bit selects working or file register.
// - Arithmetic right shift keeps MSb, LSb to carry.
// - Add with carry-in, steer, update flags.
// - Bit clear changes one bit, no flags.
// - Bit test skips next when bit clear.
// - Relative jump adds signed 9-bit offset.
// - Relative jump takes two instruction cycles.

package abx_pkg;

  // ****************************************
  // Bus and register map
  // ****************************************
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_WORK = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_PC = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_CMD = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_STATE = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_CYCLES = 12'h014;
  localparam logic [2:0] FILE_REGION = 3'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int STAT_C_BIT = 0;
  localparam int STAT_HC_BIT = 1;
  localparam int STAT_Z_BIT = 2;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DEST_BIT = 3;
  localparam int CMD_FIDX_LSB = 4;
  localparam int CMD_BIT_LSB = 11;
  localparam int CMD_K_LSB = 16;
  localparam int K_W = 9;

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0] RST_WORK = 8'h00;
  localparam logic [7:0] RST_FILE = 8'h00;
  localparam logic [31:0] RST_CMD = 32'h0000_0000;
  localparam int FILE_DEPTH = 128;
  localparam int PC_WIDTH = 15;
  localparam int JUMP_CYCLES = 2;

  // ****************************************
  // Operations and states
  // ****************************************
  typedef enum logic [2:0] {
    OP_NOP = 3'b000,
    OP_ADD = 3'b001,
    OP_ASR = 3'b010,
    OP_ADDC = 3'b011,
    OP_BCLR = 3'b100,
    OP_BTSZ = 3'b101,
    OP_JUMP = 3'b110,
    OP_RSVD = 3'b111
  } abx_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_REFILL = 2'b10
  } abx_state_t;

endpackage : abx_pkg

// ===== hw/abx_alu.sv
// Combinational datapath for add, add with carry, shift and bit ops.
// Assumes operands are stable for the cycle in which they are used.
`timescale 1ns/1ps
`default_nettype none

module abx_alu
  import abx_pkg::*;
(
  // Operands
  input wire abx_op_t op,
  input wire logic [7:0] work,
  input wire logic [7:0] fval,
  input wire logic carry_in,
  input wire logic [2:0] bit_idx,
  // Results
  output logic [7:0] result,
  output logic carry_out,
  output logic half_out,
  output logic zero_out,
  output logic upd_c,
  output logic upd_hc,
  output logic upd_z,
  output logic has_result,
  output logic bit_val
);

  logic [8:0] sum9;
  logic [4:0] low5;
  logic cin;

  always_comb begin
    cin = (op == OP_ADDC) ? carry_in : 1'b0;
    sum9 = {1'b0, work} + {1'b0, fval} + {8'h00, cin};
    low5 = {1'b0, work[3:0]} + {1'b0, fval[3:0]} + {4'h0, cin};
    bit_val = fval[bit_idx];
    result = fval;
    carry_out = carry_in;
    half_out = low5[4];
    upd_c = 1'b0;
    upd_hc = 1'b0;
    upd_z = 1'b0;
    has_result = 1'b0;
    unique case (op)
      OP_ADD, OP_ADDC: begin
        result = sum9[7:0];
        carry_out = sum9[8];
        upd_c = 1'b1;
        upd_hc = 1'b1;
        upd_z = 1'b1;
        has_result = 1'b1;
      end
      OP_ASR: begin
        result = {fval[7], fval[7:1]};
        carry_out = fval[0];
        upd_c = 1'b1;
        upd_z = 1'b1;
        has_result = 1'b1;
      end
      OP_BCLR: begin
        result = fval & ~(8'h01 << bit_idx);
        has_result = 1'b1;
      end
      OP_NOP, OP_BTSZ, OP_JUMP, OP_RSVD: begin
        result = fval;
      end
    endcase
    zero_out = (result == 8'h00);
  end

endmodule : abx_alu
`default_nettype wire

// ===== hw/abx_exec_top.sv
// Execution block with AXI4-Lite register access and a flop file.
// Assumes one clock, synchronous active-low reset, well-formed AXI master.
`timescale 1ns/1ps
`default_nettype none

module abx_exec_top
  import abx_pkg::*;
#(
  parameter int DEPTH = FILE_DEPTH,
  parameter int PC_W = PC_WIDTH
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclk_en,
  // Write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // Write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // Write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // Read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Core state
  output logic [PC_W-1:0] pc_out,
  output logic busy_out
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic map_ok(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = {a[ADDR_W-1:2], 2'b00};
    map_ok = (w == OFF_WORK) || (w == OFF_STATUS) || (w == OFF_PC) ||
             (w == OFF_CMD) || (w == OFF_STATE) || (w == OFF_CYCLES) ||
             (a[ADDR_W-1:9] == FILE_REGION);
  endfunction : map_ok

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction : merge

  // ****************************************
  // State
  // ****************************************
  abx_state_t state_q;
  logic [7:0] work_q;
  logic [7:0] file_q [DEPTH];
  logic c_q, hc_q, z_q;
  logic skip_q;
  logic [PC_W-1:0] pc_q;
  logic [31:0] cmd_q;
  logic [31:0] cycles_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_got_q, w_got_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic busy_q;

  // Command fields
  abx_op_t op;
  logic dest;
  logic [6:0] fidx;
  logic [2:0] bidx;
  logic [K_W-1:0] kofs;
  logic [7:0] fsel;
  assign op = abx_op_t'(cmd_q[CMD_OP_LSB +: 3]);
  assign dest = cmd_q[CMD_DEST_BIT];
  assign fidx = cmd_q[CMD_FIDX_LSB +: 7];
  assign bidx = cmd_q[CMD_BIT_LSB +: 3];
  assign kofs = cmd_q[CMD_K_LSB +: K_W];
  assign fsel = file_q[fidx];

  logic [7:0] res;
  logic c_n, hc_n, z_n, upd_c, upd_hc, upd_z, has_res, bit_val;

  abx_alu u_alu (
    .op(op),
    .work(work_q),
    .fval(fsel),
    .carry_in(c_q),
    .bit_idx(bidx),
    .result(res),
    .carry_out(c_n),
    .half_out(hc_n),
    .zero_out(z_n),
    .upd_c(upd_c),
    .upd_hc(upd_hc),
    .upd_z(upd_z),
    .has_result(has_res),
    .bit_val(bit_val)
  );

  logic exec_do, discard, to_file, to_work;
  assign exec_do = (state_q == ST_EXEC) && !skip_q;
  assign discard = (state_q == ST_EXEC) && skip_q;
  assign to_file = exec_do && has_res && (dest || op == OP_BCLR);
  assign to_work = exec_do && has_res && !dest && op != OP_BCLR;

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  logic wr_fire, idle, sw_wr;
  logic [ADDR_W-1:0] wa;
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
  assign idle = (state_q == ST_IDLE);
  assign wa = {awaddr_q[ADDR_W-1:2], 2'b00};
  assign sw_wr = wr_fire && idle && map_ok(awaddr_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      aw_got_q <= 1'b0;
      awaddr_q <= '0;
    end else if (aclk_en) begin
      if (awvalid && awready_q) begin
        awaddr_q <= awaddr;
        aw_got_q <= 1'b1;
        awready_q <= 1'b0;
      end else if (wr_fire) begin
        aw_got_q <= 1'b0;
      end else if (!aw_got_q && !bvalid_q) begin
        awready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b0;
      w_got_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (aclk_en) begin
      if (wvalid && wready_q) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        w_got_q <= 1'b1;
        wready_q <= 1'b0;
      end else if (wr_fire) begin
        w_got_q <= 1'b0;
      end else if (!w_got_q && !bvalid_q) begin
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (aclk_en) begin
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= sw_wr ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  logic [31:0] rd_word;
  logic [ADDR_W-1:0] ra;
  assign ra = {araddr[ADDR_W-1:2], 2'b00};

  always_comb begin
    rd_word = 32'h0000_0000;
    if (araddr[ADDR_W-1:9] == FILE_REGION) begin
      rd_word = {24'h00_0000, file_q[araddr[8:2]]};
    end else if (ra == OFF_WORK) begin
      rd_word = {24'h00_0000, work_q};
    end else if (ra == OFF_STATUS) begin
      rd_word = {29'h0000_0000, z_q, hc_q, c_q};
    end else if (ra == OFF_PC) begin
      rd_word = {{(32-PC_W){1'b0}}, pc_q};
    end else if (ra == OFF_CMD) begin
      rd_word = cmd_q;
    end else if (ra == OFF_STATE) begin
      rd_word = {28'h000_0000, state_q, skip_q, busy_q};
    end else if (ra == OFF_CYCLES) begin
      rd_word = cycles_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (aclk_en) begin
      if (arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= map_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
      end else if (!rvalid_q) begin
        arready_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Instruction sequencing
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
      cmd_q <= RST_CMD;
    end else if (aclk_en) begin
      unique case (state_q)
        ST_IDLE: begin
          if (sw_wr && wa == OFF_CMD) begin
            cmd_q <= merge(cmd_q, wdata_q, wstrb_q);
            state_q <= ST_EXEC;
            busy_q <= 1'b1;
          end
        end
        ST_EXEC: begin
          if (exec_do && op == OP_JUMP) begin
            state_q <= ST_REFILL;
          end else begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
          end
        end
        ST_REFILL: begin
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      skip_q <= 1'b0;
    end else if (aclk_en) begin
      if (exec_do && op == OP_BTSZ && !bit_val) begin
        skip_q <= 1'b1;
      end else if (discard) begin
        skip_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= '0;
    end else if (aclk_en) begin
      if (exec_do && op == OP_JUMP) begin
        pc_q <= pc_q + PC_W'(1) + PC_W'($signed(kofs));
      end else if (state_q == ST_EXEC) begin
        pc_q <= pc_q + PC_W'(1);
      end else if (sw_wr && wa == OFF_PC) begin
        pc_q <= PC_W'(merge({{(32-PC_W){1'b0}}, pc_q}, wdata_q, wstrb_q));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cycles_q <= '0;
    end else if (aclk_en && state_q != ST_IDLE) begin
      cycles_q <= cycles_q + 32'h0000_0001;
    end
  end

  // ****************************************
  // Working register, flags, file
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      work_q <= RST_WORK;
    end else if (aclk_en) begin
      if (to_work) begin
        work_q <= res;
      end else if (sw_wr && wa == OFF_WORK && wstrb_q[0]) begin
        work_q <= wdata_q[7:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c_q <= 1'b0;
      hc_q <= 1'b0;
      z_q <= 1'b0;
    end else if (aclk_en) begin
      if (exec_do) begin
        if (upd_c) c_q <= c_n;
        if (upd_hc) hc_q <= hc_n;
        if (upd_z) z_q <= z_n;
      end else if (sw_wr && wa == OFF_STATUS && wstrb_q[0]) begin
        c_q <= wdata_q[STAT_C_BIT];
        hc_q <= wdata_q[STAT_HC_BIT];
        z_q <= wdata_q[STAT_Z_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        file_q[i] <= RST_FILE;
      end
    end else if (aclk_en) begin
      if (to_file) begin
        file_q[fidx] <= res;
      end else if (sw_wr && awaddr_q[ADDR_W-1:9] == FILE_REGION && wstrb_q[0]) begin
        file_q[awaddr_q[8:2]] <= wdata_q[7:0];
      end
    end
  end

  // Outputs
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign pc_out = pc_q;
  assign busy_out = busy_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [8:0] exp_add, exp_addc;
  assign exp_add = {1'b0, work_q} + {1'b0, fsel};
  assign exp_addc = {1'b0, work_q} + {1'b0, fsel} + {8'h00, c_q};

  chk_add_work: assert property (aclk_en && exec_do && op == OP_ADD && !dest
    |=> {c_q, work_q} == $past(exp_add)) else $error("add to work wrong");
  chk_dest_file: assert property (aclk_en && exec_do && op == OP_ADD && dest
    |=> file_q[$past(fidx)] == $past(exp_add[7:0]) && $stable(work_q))
    else $error("add to file wrong");
  chk_asr_shift: assert property (aclk_en && exec_do && op == OP_ASR && !dest
    |=> work_q == {$past(fsel[7]), $past(fsel[7:1])} && c_q == $past(fsel[0]))
    else $error("shift wrong");
  chk_addc_sum: assert property (aclk_en && exec_do && op == OP_ADDC && !dest
    |=> {c_q, work_q} == $past(exp_addc)) else $error("add carry wrong");
  chk_bclr_flags: assert property (aclk_en && exec_do && op == OP_BCLR
    |=> file_q[$past(fidx)] == ($past(fsel) & ~(8'h01 << $past(bidx)))
    && $stable({c_q, hc_q, z_q}))
    else $error("bit clear wrong");
  chk_skip_nop: assert property (aclk_en && discard
    |=> $stable(work_q) && $stable({c_q, hc_q, z_q}) && !skip_q)
    else $error("skipped op acted");
  chk_jump_pc: assert property (aclk_en && exec_do && op == OP_JUMP
    |=> pc_q == $past(pc_q) + PC_W'(1) + PC_W'($signed($past(kofs)))
    && $stable({c_q, hc_q, z_q}))
    else $error("jump target wrong");
  chk_jump_two: assert property (aclk_en && exec_do && op == OP_JUMP
    |=> state_q == ST_REFILL ##1 (!aclk_en || state_q == ST_IDLE) [*1])
    else $error("jump not two cycles");
  chk_zero_flag: assert property (aclk_en && exec_do && op == OP_ADD && !dest
    |=> z_q == (work_q == 8'h00)) else $error("zero flag wrong");
  chk_half_carry: assert property (aclk_en && exec_do && op == OP_ADD
    |=> hc_q == $past(work_q[3:0] + fsel[3:0] > 5'h0F)) else $error("half carry wrong");

  cov_jump: cover property (exec_do && op == OP_JUMP ##1 state_q == ST_REFILL);
  cov_skip: cover property (discard);
  cov_addc: cover property (exec_do && op == OP_ADDC && c_q);

endmodule : abx_exec_top
`default_nettype wire

// ===== sim/cpu_arith_bit_branch_exec_tb_top.sv
// Self-checking bench for the execution block, random and corner instructions.
// Assumes an AXI4-Lite slave holding work, flag, PC, command and file registers.
`timescale 1ns/1ps
`default_nettype none

module cpu_arith_bit_branch_exec_tb_top;
  import abx_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, busy_out;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic [PC_WIDTH-1:0] pc_out;
  logic skip_q = 1'b0;
  integer seed = 32'h5DAC;
  int err_count = 0, cmp_count = 0;

  always #5 aclk = ~aclk;

  abx_exec_top u_dut (
    .aclk(aclk), .aresetn(aresetn), .aclk_en(1'b1),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .pc_out(pc_out), .busy_out(busy_out)
  );

  // ****************************************
  // Report and compare
  // ****************************************
  task automatic test_done;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    r = 2'h3;
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        done = 1'b1;
      end
    end
    bready <= 1'b0;
    if (!done) begin
      err_count++;
      test_done();
    end
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    d = 32'h0;
    r = 2'h3;
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        done = 1'b1;
      end
    end
    rready <= 1'b0;
    if (!done) begin
      err_count++;
      test_done();
    end
    @(posedge aclk);
  endtask : axi_rd

  function automatic logic [11:0] faddr(input logic [6:0] idx);
    return 12'h200 + {3'h0, idx, 2'b00};
  endfunction : faddr

  // ****************************************
  // One instruction with bench model
  // ****************************************
  task automatic do_case(input logic [2:0] op, input logic [7:0] w, input logic [7:0] f,
                         input logic [2:0] st, input logic [6:0] idx, input logic [2:0] b,
                         input logic dst, input logic [8:0] k, input logic [14:0] p);
    logic [1:0] r;
    logic [31:0] d, cyc0;
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] ew, ef, res;
    logic [2:0] es;
    logic [14:0] ep;
    logic cin, run;
    int n;
    axi_wr(OFF_WORK, {24'h0, w}, r);
    axi_wr(faddr(idx), {24'h0, f}, r);
    axi_wr(OFF_STATUS, {29'h0, st}, r);
    axi_wr(OFF_PC, {17'h0, p}, r);
    axi_rd(OFF_CYCLES, cyc0, r);
    ew = w; ef = f; es = st; ep = p + 15'h1;
    run = !skip_q;
    skip_q = 1'b0;
    if (run) begin
      case (op)
        OP_ADD, OP_ADDC: begin
          cin = (op == OP_ADDC) ? st[0] : 1'b0;
          s = {1'b0, w} + {1'b0, f} + {8'h0, cin};
          h = {1'b0, w[3:0]} + {1'b0, f[3:0]} + {4'h0, cin};
          res = s[7:0];
          es = {res == 8'h00, h[4], s[8]};
          if (dst) ef = res; else ew = res;
        end
        OP_ASR: begin
          res = {f[7], f[7:1]};
          es = {res == 8'h00, st[1], f[0]};
          if (dst) ef = res; else ew = res;
        end
        OP_BCLR: ef[b] = 1'b0;
        OP_BTSZ: skip_q = !f[b];
        OP_JUMP: ep = p + 15'h1 + {{6{k[8]}}, k};
        default: ;
      endcase
    end
    axi_wr(OFF_CMD, {7'h0, k, 2'h0, b, idx, dst, op}, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    for (n = 0; n < 50 && busy_out !== 1'b0; n++) @(posedge aclk);
    if (n == 50) begin
      err_count++;
      test_done();
    end
    axi_rd(OFF_WORK, d, r);
    check(d, {24'h0, ew});
    axi_rd(faddr(idx), d, r);
    check(d, {24'h0, ef});
    axi_rd(OFF_STATUS, d, r);
    check(d, {29'h0, es});
    axi_rd(OFF_PC, d, r);
    check(d, {17'h0, ep});
    check({17'h0, pc_out}, {17'h0, ep});
    check({30'h0, r}, {30'h0, RESP_OKAY});
    axi_rd(OFF_STATE, d, r);
    check(d, {30'h0, skip_q, 1'b0});
    axi_rd(OFF_CYCLES, d, r);
    check(d - cyc0, (run && op == OP_JUMP) ? 32'(JUMP_CYCLES) : 32'h1);
  endtask : do_case

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] d, r1, r2;
    logic [1:0] r;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(OFF_WORK, d, r);
    check(d, 32'h0);
    axi_rd(OFF_STATUS, d, r);
    check(d, 32'h0);
    axi_rd(OFF_PC, d, r);
    check(d, 32'h0);
    axi_rd(faddr(7'd127), d, r);
    check(d, 32'h0);
    axi_wr(12'h100, 32'h0000_00FF, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_rd(12'h100, d, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    do_case(OP_ADD, 8'hFF, 8'h01, 3'h0, 7'd127, 3'h0, 1'b0, 9'h000, 15'h0000);
    do_case(OP_ADD, 8'h08, 8'h08, 3'h7, 7'd0, 3'h0, 1'b1, 9'h000, 15'h0010);
    do_case(OP_ADDC, 8'h0F, 8'h00, 3'h1, 7'd0, 3'h0, 1'b1, 9'h000, 15'h0020);
    do_case(OP_ADDC, 8'hFF, 8'hFF, 3'h1, 7'd5, 3'h0, 1'b0, 9'h000, 15'h0020);
    do_case(OP_ASR, 8'h11, 8'h81, 3'h0, 7'd3, 3'h0, 1'b0, 9'h000, 15'h0030);
    do_case(OP_ASR, 8'h11, 8'h01, 3'h2, 7'd3, 3'h0, 1'b1, 9'h000, 15'h0030);
    do_case(OP_BCLR, 8'h00, 8'hFF, 3'h7, 7'd9, 3'h7, 1'b0, 9'h000, 15'h0040);
    do_case(OP_JUMP, 8'h00, 8'h00, 3'h5, 7'd1, 3'h0, 1'b0, 9'h100, 15'h0000);
    do_case(OP_JUMP, 8'h00, 8'h00, 3'h2, 7'd1, 3'h0, 1'b0, 9'h0FF, 15'h7FFF);
    do_case(OP_BTSZ, 8'h00, 8'h7F, 3'h0, 7'd2, 3'h7, 1'b0, 9'h000, 15'h0050);
    do_case(OP_JUMP, 8'h00, 8'h00, 3'h0, 7'd2, 3'h0, 1'b0, 9'h040, 15'h0051);
    do_case(OP_BTSZ, 8'h00, 8'h80, 3'h0, 7'd2, 3'h7, 1'b0, 9'h000, 15'h0060);
    do_case(OP_ADD, 8'h01, 8'h02, 3'h0, 7'd2, 3'h0, 1'b0, 9'h000, 15'h0061);
    for (int i = 0; i < 120; i++) begin
      r1 = $random(seed);
      r2 = $random(seed);
      do_case(r1[2:0], r1[10:3], r1[18:11], r1[21:19], r2[6:0], r2[9:7], r2[10], r2[19:11],
              r2[30:16]);
    end
    test_done();
  end

endmodule : cpu_arith_bit_branch_exec_tb_top

`default_nettype wire
